// ===== shared/rgcm_defs.svh
`ifndef RGCM_DEFS_SVH
`define RGCM_DEFS_SVH

// Register offsets on the configuration port, with the reset value and the unmapped read value.
`define RGCM_OFS_PIN0   8'h00
`define RGCM_OFS_PIN1   8'h40
`define RGCM_CFG_RST    8'h00
`define RGCM_RD_UNMAP   8'h00

// Field positions, shared by both pin registers except the trigger bit, which only pin 1 has.
`define RGCM_BIT_DRIVE  7
`define RGCM_BIT_TRIG   6
`define RGCM_BIT_DIR    5
`define RGCM_BIT_LEVEL  4
`define RGCM_SRC_HI     3
`define RGCM_SRC_LO     0

// Writable bits; pin 0 has a reserved bit 6 that reads as zero.
`define RGCM_WMASK0     8'haf
`define RGCM_WMASK1     8'hef

// Output source codes.
`define RGCM_SEL_WAKE   4'h0
`define RGCM_SEL_DISC   4'h1
`define RGCM_SEL_UNSQ   4'h2
`define RGCM_SEL_SE1    4'h3
`define RGCM_SEL_DFLT   4'h4
`define RGCM_SEL_HOST   4'h5
`define RGCM_SEL_PERI   4'h6
`define RGCM_SEL_CONN   4'h7
`define RGCM_SEL_RST    4'h8
`define RGCM_SEL_L0     4'h9
`define RGCM_SEL_L1     4'ha
`define RGCM_SEL_L2     4'hb
`define RGCM_SEL_TEST   4'hc
`define RGCM_SEL_HIGH   4'hd
`define RGCM_SEL_LOW    4'he
`define RGCM_SEL_OVP    4'hf

`endif

// ===== shared/rgcm_pkg.sv
package rgcm_pkg;

    // Live repeater indications that pin 1 can show.
    typedef struct packed {
        logic remote_wake;
        logic ls_fs_disc;
        logic hs_unsquelch;
        logic hs_disconnect_se1_tx;
        logic role_default;
        logic role_host;
        logic role_periph;
        logic connected;
        logic reset_active;
        logic link_l0;
        logic link_l1;
        logic link_l2;
        logic hs_test_indication;
        logic overvoltage_flag;
    } rgcm_rpt_state_t;

    // Register port request.
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rgcm_reg_req_t;

    // One pin's pad signals.
    typedef struct packed {
        logic out;
        logic oe;
    } rgcm_pad_t;

    // State of one pin driver.
    typedef struct packed {
        logic [2:0] sync;
        logic       level;
        logic       chg;
        logic [3:0] warm;
        rgcm_pad_t  pad;
    } rgcm_pin_st_t;

    // State of the top block.
    typedef struct packed {
        logic [7:0] cfg0;
        logic [7:0] cfg1;
        logic [7:0] rdata;
        logic       irq;
    } rgcm_top_st_t;

endpackage

// ===== hw/rgcm_pin_drv.sv
`timescale 1ns/1ps
`include "rgcm_defs.svh"

module rgcm_pin_drv (
    // Clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    // Pin
    input  wire logic              pad_in,
    output rgcm_pkg::rgcm_pad_t    pad_out,
    // Control
    input  wire logic              drive_pp_in,
    input  wire logic              dir_out_in,
    input  wire logic              value_in,
    // Status
    output logic                   level_out,
    output logic                   change_out
);
    import rgcm_pkg::*;

    rgcm_pin_st_t st_q;
    rgcm_pin_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.sync = {st_q.sync[1:0], pad_in};
        // Ones shift in from reset; until they reach the top the filter still holds reset values,
        // so the first settled level after reset is loaded without counting as an edge.
        st_d.warm = (st_q.warm << 1) | 4'h1;
        // A change counts only once the second and third stages agree.
        if (st_q.sync[1] == st_q.sync[2]) begin // see R15
            st_d.level = st_q.sync[2];
        end
        st_d.chg = (st_d.level != st_q.level) && st_q.warm[$left(st_q.warm)]; // see R15
        if (!dir_out_in) begin
            st_d.pad = '{out: 1'b0, oe: 1'b0}; // see R14
        end else if (drive_pp_in) begin
            st_d.pad = '{out: value_in, oe: 1'b1}; // see R1 R2
        end else begin
            // Open drain only ever pulls low and releases for a high.
            st_d.pad = '{out: 1'b0, oe: ~value_in}; // see R14
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pad_out    = st_q.pad;
    assign level_out  = st_q.level;
    assign change_out = st_q.chg;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    property p_chg_real;
        change_out |-> level_out != $past(level_out);
    endproperty
    a_chg_real: assert property (p_chg_real) else $error("change pulse without level change"); // see R15

    property p_level_filtered;
        (pad_in [*4]) |=> level_out;
    endproperty
    a_level_filtered: assert property (p_level_filtered) else $error("stable high pad not seen as level"); // see R5 R6

endmodule

// ===== hw/rgcm_top.sv
`timescale 1ns/1ps
`include "rgcm_defs.svh"

// Functional notes
// R1: Pin-1 bit 7 picks open-drain when zero, push-pull when one.
// R2: Pin-0 drive type: zero open-drain, one push-pull, resets to open-drain.
// R3: Pin-1 bit 6: zero edge trigger; one level, interrupt follows pin-1 level.
// R4: Bit 5 sets direction, zero input and one output, on both pins.
// R5: Pin-1 bit 4 is read-only and returns the sampled pin level.
// R6: Pin-0 level field is read-only and returns the current pin level.
// R7: Pin-1 codes 0h-3h show wake, disconnect, unsquelch and SE1 transmit.
// R8: Codes 4h, 5h, 6h show awaiting role, host role and peripheral role.
// R9: Codes 7h-Bh show connected, reset, L0, L1 and L2 link states.
// R10: Code Ch shows the high-speed test indication in host L0.
// R11: Pin-1 code Dh drives constant high, Eh constant low.
// R12: Code Fh follows the over-voltage flag of the data lines.
// R13: Pin-0 codes Dh and Eh force high and low; field resets zero.
// R14: Input direction disables the driver; open-drain only pulls low.
// R15: Pin-1 input is synchronised before edge detection for interrupts.

module rgcm_top (
    // Clock and reset
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_in,
    // Register port
    input  rgcm_pkg::rgcm_reg_req_t       reg_req_in,
    output logic [7:0]                    reg_rdata_out,
    // Repeater indications
    input  rgcm_pkg::rgcm_rpt_state_t     rpt_state_in,
    // Pin 0
    input  wire logic                     pin0_pad_in,
    output rgcm_pkg::rgcm_pad_t           pin0_pad_out,
    // Pin 1
    input  wire logic                     pin1_pad_in,
    output rgcm_pkg::rgcm_pad_t           pin1_pad_out,
    // Interrupt request towards the interrupt pin
    output logic                          pin1_irq_out
);
    import rgcm_pkg::*;

    rgcm_top_st_t st_q;
    rgcm_top_st_t st_d;

    logic pin0_level;
    logic pin1_level;
    logic pin0_chg;
    logic pin1_chg;
    logic pin0_value;
    logic pin1_value;

    // Picks the pin-1 indication for a given output source code.
    function automatic logic pin1_select(input logic [3:0] src, input rgcm_rpt_state_t rs);
        logic v;
        v = 1'b0;
        case (src)
            `RGCM_SEL_WAKE: v = rs.remote_wake; // see R7
            `RGCM_SEL_DISC: v = rs.ls_fs_disc;
            `RGCM_SEL_UNSQ: v = rs.hs_unsquelch;
            `RGCM_SEL_SE1:  v = rs.hs_disconnect_se1_tx;
            `RGCM_SEL_DFLT: v = rs.role_default; // see R8
            `RGCM_SEL_HOST: v = rs.role_host;
            `RGCM_SEL_PERI: v = rs.role_periph;
            `RGCM_SEL_CONN: v = rs.connected; // see R9
            `RGCM_SEL_RST:  v = rs.reset_active;
            `RGCM_SEL_L0:   v = rs.link_l0;
            `RGCM_SEL_L1:   v = rs.link_l1;
            `RGCM_SEL_L2:   v = rs.link_l2;
            `RGCM_SEL_TEST: v = rs.hs_test_indication; // see R10
            `RGCM_SEL_HIGH: v = 1'b1; // see R11
            `RGCM_SEL_LOW:  v = 1'b0;
            `RGCM_SEL_OVP:  v = rs.overvoltage_flag; // see R12
            default:        v = 1'b0;
        endcase
        return v;
    endfunction

    // Pin 0 offers only the forced levels; other codes hold the pin low.
    function automatic logic pin0_select(input logic [3:0] src);
        return src == `RGCM_SEL_HIGH; // see R13
    endfunction

    // Read value: stored fields with the live level in the status bit.
    function automatic logic [7:0] read_merge(input logic [7:0] cfg, input logic lvl);
        logic [7:0] r;
        r = cfg;
        r[`RGCM_BIT_LEVEL] = lvl; // see R5 R6
        return r;
    endfunction

    // True when the port writes the register at the given offset in this cycle.
    function automatic logic write_hit(input rgcm_reg_req_t req, input logic [7:0] ofs);
        return req.wr && (req.addr == ofs);
    endfunction

    assign pin0_value = pin0_select(st_q.cfg0[`RGCM_SRC_HI:`RGCM_SRC_LO]);
    assign pin1_value = pin1_select(st_q.cfg1[`RGCM_SRC_HI:`RGCM_SRC_LO], rpt_state_in);

    always_comb begin
        st_d = st_q;
        if (write_hit(reg_req_in, `RGCM_OFS_PIN0)) begin
            st_d.cfg0 = reg_req_in.wdata & `RGCM_WMASK0; // see R2 R4 R13
        end
        if (write_hit(reg_req_in, `RGCM_OFS_PIN1)) begin
            st_d.cfg1 = reg_req_in.wdata & `RGCM_WMASK1; // see R1 R3 R4
        end
        case (reg_req_in.addr)
            `RGCM_OFS_PIN0: st_d.rdata = read_merge(st_q.cfg0, pin0_level); // see R6
            `RGCM_OFS_PIN1: st_d.rdata = read_merge(st_q.cfg1, pin1_level); // see R5
            default:        st_d.rdata = `RGCM_RD_UNMAP;
        endcase
        // Level trigger mirrors the pin; edge trigger gives a pulse per change.
        if (st_q.cfg1[`RGCM_BIT_TRIG]) begin
            st_d.irq = pin1_level; // see R3
        end else begin
            st_d.irq = pin1_chg; // see R3 R15
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '{cfg0: `RGCM_CFG_RST, cfg1: `RGCM_CFG_RST, rdata: `RGCM_RD_UNMAP, irq: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    rgcm_pin_drv u_pin0 (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .pad_in      (pin0_pad_in),
        .pad_out     (pin0_pad_out),
        .drive_pp_in (st_q.cfg0[`RGCM_BIT_DRIVE]),
        .dir_out_in  (st_q.cfg0[`RGCM_BIT_DIR]),
        .value_in    (pin0_value),
        .level_out   (pin0_level),
        .change_out  (pin0_chg)
    );

    rgcm_pin_drv u_pin1 (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .pad_in      (pin1_pad_in),
        .pad_out     (pin1_pad_out),
        .drive_pp_in (st_q.cfg1[`RGCM_BIT_DRIVE]),
        .dir_out_in  (st_q.cfg1[`RGCM_BIT_DIR]),
        .value_in    (pin1_value),
        .level_out   (pin1_level),
        .change_out  (pin1_chg)
    );

    assign reg_rdata_out = st_q.rdata;
    assign pin1_irq_out  = st_q.irq;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    property p_pin1_od;
        st_q.cfg1[`RGCM_BIT_DIR] && !st_q.cfg1[`RGCM_BIT_DRIVE]
            |=> !pin1_pad_out.out && (pin1_pad_out.oe == !$past(pin1_value));
    endproperty
    a_pin1_od: assert property (p_pin1_od) else $error("pin 1 open drain drive wrong"); // see R1

    property p_pin0_pp;
        st_q.cfg0[`RGCM_BIT_DIR] && st_q.cfg0[`RGCM_BIT_DRIVE]
            |=> pin0_pad_out.oe && (pin0_pad_out.out == $past(pin0_value));
    endproperty
    a_pin0_pp: assert property (p_pin0_pp) else $error("pin 0 push pull drive wrong"); // see R2

    property p_level_irq;
        st_q.cfg1[`RGCM_BIT_TRIG] |=> pin1_irq_out == $past(pin1_level);
    endproperty
    a_level_irq: assert property (p_level_irq) else $error("level interrupt does not follow pin 1"); // see R3

    property p_input_off;
        !st_q.cfg1[`RGCM_BIT_DIR] && !st_q.cfg0[`RGCM_BIT_DIR] |=> !pin1_pad_out.oe && !pin0_pad_out.oe;
    endproperty
    a_input_off: assert property (p_input_off) else $error("driver enabled in input direction"); // see R4 R14

    property p_rd_pin1;
        reg_req_in.addr == `RGCM_OFS_PIN1 |=> reg_rdata_out[`RGCM_BIT_LEVEL] == $past(pin1_level);
    endproperty
    a_rd_pin1: assert property (p_rd_pin1) else $error("pin 1 level read wrong"); // see R5

    property p_rd_pin0;
        reg_req_in.addr == `RGCM_OFS_PIN0
            |=> reg_rdata_out == {$past(st_q.cfg0[`RGCM_BIT_DRIVE]), 1'b0, $past(st_q.cfg0[`RGCM_BIT_DIR]),
                                  $past(pin0_level), $past(st_q.cfg0[`RGCM_SRC_HI:`RGCM_SRC_LO])};
    endproperty
    a_rd_pin0: assert property (p_rd_pin0) else $error("pin 0 read wrong"); // see R6

    // Codes up to Ch pick the indication word from its top bit downwards.
    property p_pin1_src;
        st_q.cfg1[`RGCM_BIT_DIR] && st_q.cfg1[`RGCM_BIT_DRIVE]
            && (st_q.cfg1[`RGCM_SRC_HI:`RGCM_SRC_LO] <= `RGCM_SEL_TEST)
            |=> pin1_pad_out.out
                == $past(rpt_state_in[$bits(rgcm_rpt_state_t) - 1 - st_q.cfg1[`RGCM_SRC_HI:`RGCM_SRC_LO]]);
    endproperty
    a_pin1_src: assert property (p_pin1_src) else $error("pin 1 source mux wrong"); // see R7 R8 R9 R10

    property p_force_high;
        st_q.cfg1[`RGCM_BIT_DIR] && st_q.cfg1[`RGCM_BIT_DRIVE]
            && st_q.cfg1[`RGCM_SRC_HI:`RGCM_SRC_LO] == `RGCM_SEL_HIGH |=> pin1_pad_out.out;
    endproperty
    a_force_high: assert property (p_force_high) else $error("pin 1 not forced high"); // see R11

    property p_ovp;
        st_q.cfg1[`RGCM_BIT_DIR] && st_q.cfg1[`RGCM_BIT_DRIVE] && rpt_state_in.overvoltage_flag
            && st_q.cfg1[`RGCM_SRC_HI:`RGCM_SRC_LO] == `RGCM_SEL_OVP |=> pin1_pad_out.out;
    endproperty
    a_ovp: assert property (p_ovp) else $error("over-voltage not shown on pin 1"); // see R12

    property p_pin0_low;
        st_q.cfg0[`RGCM_BIT_DIR] && st_q.cfg0[`RGCM_SRC_HI:`RGCM_SRC_LO] == `RGCM_SEL_LOW
            |=> !pin0_pad_out.out;
    endproperty
    a_pin0_low: assert property (p_pin0_low) else $error("pin 0 not forced low"); // see R13

    property p_edge_irq;
        !st_q.cfg1[`RGCM_BIT_TRIG] && !pin1_chg |=> !pin1_irq_out;
    endproperty
    a_edge_irq: assert property (p_edge_irq) else $error("edge interrupt without pin change"); // see R15

    // Pin 0 in open drain pulls low for every code but the forced high, which releases it.
    property p_pin0_od;
        st_q.cfg0[`RGCM_BIT_DIR] && !st_q.cfg0[`RGCM_BIT_DRIVE]
            |=> !pin0_pad_out.out
                && (pin0_pad_out.oe == ($past(st_q.cfg0[`RGCM_SRC_HI:`RGCM_SRC_LO]) != `RGCM_SEL_HIGH));
    endproperty
    a_pin0_od: assert property (p_pin0_od) else $error("pin 0 open drain drive wrong"); // see R2 R14

    property p_pin0_high;
        st_q.cfg0[`RGCM_BIT_DIR] && st_q.cfg0[`RGCM_BIT_DRIVE]
            && st_q.cfg0[`RGCM_SRC_HI:`RGCM_SRC_LO] == `RGCM_SEL_HIGH |=> pin0_pad_out.oe && pin0_pad_out.out;
    endproperty
    a_pin0_high: assert property (p_pin0_high) else $error("pin 0 not forced high"); // see R13

    // A forced low is driven in both output types, since open drain can pull low.
    property p_force_low;
        st_q.cfg1[`RGCM_BIT_DIR] && st_q.cfg1[`RGCM_SRC_HI:`RGCM_SRC_LO] == `RGCM_SEL_LOW
            |=> pin1_pad_out.oe && !pin1_pad_out.out;
    endproperty
    a_force_low: assert property (p_force_low) else $error("pin 1 not forced low"); // see R11

    property p_ovp_clear;
        st_q.cfg1[`RGCM_BIT_DIR] && st_q.cfg1[`RGCM_BIT_DRIVE] && !rpt_state_in.overvoltage_flag
            && st_q.cfg1[`RGCM_SRC_HI:`RGCM_SRC_LO] == `RGCM_SEL_OVP |=> !pin1_pad_out.out;
    endproperty
    a_ovp_clear: assert property (p_ovp_clear) else $error("pin 1 shows over-voltage without flag"); // see R12

    // Each pin on its own: an input never drives, whatever the other pin does.
    property p_pin1_in_off;
        !st_q.cfg1[`RGCM_BIT_DIR] |=> !pin1_pad_out.oe && !pin1_pad_out.out;
    endproperty
    a_pin1_in_off: assert property (p_pin1_in_off) else $error("pin 1 driven as input"); // see R4 R14

    property p_pin0_in_off;
        !st_q.cfg0[`RGCM_BIT_DIR] |=> !pin0_pad_out.oe && !pin0_pad_out.out;
    endproperty
    a_pin0_in_off: assert property (p_pin0_in_off) else $error("pin 0 driven as input"); // see R4 R14

    // The status bit is never stored; it only ever comes from the live pin level.
    property p_wr_pin1;
        write_hit(reg_req_in, `RGCM_OFS_PIN1)
            |=> st_q.cfg1[`RGCM_BIT_DRIVE:`RGCM_BIT_DIR] == $past(reg_req_in.wdata[`RGCM_BIT_DRIVE:`RGCM_BIT_DIR])
                && st_q.cfg1[`RGCM_SRC_HI:`RGCM_SRC_LO] == $past(reg_req_in.wdata[`RGCM_SRC_HI:`RGCM_SRC_LO])
                && !st_q.cfg1[`RGCM_BIT_LEVEL];
    endproperty
    a_wr_pin1: assert property (p_wr_pin1) else $error("pin 1 write not stored"); // see R1 R3 R4 R7

    // Pin 0 has no trigger field, so its reserved bit must stay clear whatever is written.
    property p_wr_pin0;
        write_hit(reg_req_in, `RGCM_OFS_PIN0)
            |=> st_q.cfg0[`RGCM_BIT_DRIVE] == $past(reg_req_in.wdata[`RGCM_BIT_DRIVE])
                && st_q.cfg0[`RGCM_BIT_DIR] == $past(reg_req_in.wdata[`RGCM_BIT_DIR])
                && st_q.cfg0[`RGCM_SRC_HI:`RGCM_SRC_LO] == $past(reg_req_in.wdata[`RGCM_SRC_HI:`RGCM_SRC_LO])
                && !st_q.cfg0[`RGCM_BIT_TRIG] && !st_q.cfg0[`RGCM_BIT_LEVEL];
    endproperty
    a_wr_pin0: assert property (p_wr_pin0) else $error("pin 0 write not stored"); // see R2 R4 R13

    property p_cfg_hold;
        !reg_req_in.wr |=> $stable(st_q.cfg0) && $stable(st_q.cfg1);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed without write"); // see R2 R4 R13

    property p_rd_cfg1;
        reg_req_in.addr == `RGCM_OFS_PIN1
            |=> reg_rdata_out[`RGCM_BIT_DRIVE:`RGCM_BIT_DIR] == $past(st_q.cfg1[`RGCM_BIT_DRIVE:`RGCM_BIT_DIR])
                && reg_rdata_out[`RGCM_SRC_HI:`RGCM_SRC_LO] == $past(st_q.cfg1[`RGCM_SRC_HI:`RGCM_SRC_LO]);
    endproperty
    a_rd_cfg1: assert property (p_rd_cfg1) else $error("pin 1 fields read wrong"); // see R1 R3 R4 R7

    // Every filtered change must reach the interrupt pin in edge mode.
    property p_edge_fire;
        !st_q.cfg1[`RGCM_BIT_TRIG] && pin1_chg |=> pin1_irq_out;
    endproperty
    a_edge_fire: assert property (p_edge_fire) else $error("edge interrupt missed a pin change"); // see R3 R15

    c_level_irq: cover property (st_q.cfg1[`RGCM_BIT_TRIG] ##1 pin1_irq_out);
    c_edge_irq: cover property (!st_q.cfg1[`RGCM_BIT_TRIG] && pin1_chg ##1 pin1_irq_out);
    c_od_low: cover property (pin1_pad_out.oe && !st_q.cfg1[`RGCM_BIT_DRIVE]);
    c_pin0_high: cover property (pin0_pad_out.oe && pin0_pad_out.out);
    c_ovp_pin: cover property (st_q.cfg1[`RGCM_SRC_HI:`RGCM_SRC_LO] == `RGCM_SEL_OVP && pin1_pad_out.out);

endmodule

// ===== tb/rgcm_board.sv
`timescale 1ns/1ps

module rgcm_board (
    // Device pads
    input  rgcm_pkg::rgcm_pad_t pad0_in,
    input  rgcm_pkg::rgcm_pad_t pad1_in,
    // Board drivers
    input  wire logic [1:0]     drv_en_in,
    input  wire logic [1:0]     drv_val_in,
    // Resolved pin levels
    output logic [1:0]          pin_out
);
    // Both pins carry a board pull-up, so an open-drain release reads high.
    assign pin_out[0] = pad0_in.oe ? pad0_in.out : (drv_en_in[0] ? drv_val_in[0] : 1'b1);
    assign pin_out[1] = pad1_in.oe ? pad1_in.out : (drv_en_in[1] ? drv_val_in[1] : 1'b1);
endmodule

// ===== tb/rgcm_top_tb_top.sv
`timescale 1ns/1ps

module rgcm_top_tb_top;
    import rgcm_pkg::*;
    typedef struct packed {
        logic [2:0] kind;
        logic [7:0] exp;
    } rgcm_note_t;

    logic            ref_clk_in;
    logic            rst_in;
    rgcm_reg_req_t   req;
    logic [7:0]      rdata;
    rgcm_rpt_state_t st;
    rgcm_pad_t       pad0;
    rgcm_pad_t       pad1;
    logic            irq;
    logic [1:0]      drv_en;
    logic [1:0]      drv_val;
    logic [1:0]      pin;
    logic [31:0]     seed;
    logic            v;
    int              n_errors;
    int              cmp_count;
    int              k;
    rgcm_note_t      notes[$];
    rgcm_note_t      n;
    event            chk_ev;

    rgcm_top rgcm_top_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .rpt_state_in(st), .pin0_pad_in(pin[0]), .pin0_pad_out(pad0), .pin1_pad_in(pin[1]),
        .pin1_pad_out(pad1), .pin1_irq_out(irq));
    rgcm_board rgcm_board_i (.pad0_in(pad0), .pad1_in(pad1), .drv_en_in(drv_en), .drv_val_in(drv_val),
        .pin_out(pin));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_rdata(input logic [7:0] e);
        cmp("rdata", e, rdata);
    endtask

    task automatic cmp_pad(input string nm, input logic [7:0] e, input rgcm_pad_t p);
        cmp(nm, e, {6'h00, p});
    endtask

    task automatic cmp_irq(input logic [7:0] e);
        cmp("irq", e, {7'h00, irq});
    endtask

    task automatic cmp_oe(input string nm, input logic [7:0] e, input logic oe);
        cmp(nm, e, {7'h00, oe});
    endtask

    task automatic note(input logic [2:0] kd, input logic [7:0] e);
        notes.push_back({kd, e});
        -> chk_ev;
    endtask

    task automatic cyc(input int c);
        repeat (c) @(negedge ref_clk_in);
    endtask

    // Write strobe stays high until the next access, which keeps back-to-back writes legal.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        req = '{wr: 1'b1, addr: a, wdata: d};
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk_in);
        req = '{wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge ref_clk_in);
        note(3'h0, e);
    endtask

    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    initial forever begin
        @(chk_ev);
        while (notes.size() > 0) begin
            n = notes.pop_front();
            case (n.kind)
                3'h0: cmp_rdata(n.exp);
                3'h1: cmp_pad("pin0_pad", n.exp, pad0);
                3'h2: cmp_pad("pin1_pad", n.exp, pad1);
                3'h3: cmp_irq(n.exp);
                3'h4: cmp_oe("pin1_oe", n.exp, pad1.oe);
                default: cmp_oe("pin0_oe", n.exp, pad0.oe);
            endcase
        end
    end

    initial begin
        repeat (5000) @(posedge ref_clk_in);
        n_errors++;
        $display("mismatch watchdog expected end seen hang");
        tally_and_finish();
    end

    initial begin
        rst_in = 1'b1;
        req = '0;
        st = '0;
        drv_en = 2'h0;
        drv_val = 2'h0;
        seed = 32'he5726bd1;
        cyc(5);
        rst_in = 1'b0;
        note(3'h1, 8'h00);
        note(3'h2, 8'h00);
        note(3'h3, 8'h00);
        cyc(5);
        note(3'h3, 8'h00);
        cyc(1);
        rd(8'h00, 8'h10);
        rd(8'h40, 8'h10);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(8'h40, seed[7:0] & 8'hdf);
            wr(8'h00, seed[15:8] & 8'hdf);
            wr(8'h41, 8'hff);
            rd(8'h40, (seed[7:0] & 8'hcf) | 8'h10);
            rd(8'h00, (seed[15:8] & 8'h8f) | 8'h10);
            note(3'h4, 8'h00);
            note(3'h5, 8'h00);
        end
        for (int c = 0; c < 16; c++) begin
            seed = xs(seed);
            st = seed[13:0];
            v = (c == 13) ? 1'b1 : (c == 14) ? 1'b0 : (c == 15) ? st[0] : st[13-c];
            wr(8'h40, 8'ha0 | c[7:0]);
            cyc(5);
            rd(8'h40, 8'ha0 | c[7:0] | {3'h0, v, 4'h0});
            note(3'h2, {6'h00, v, 1'b1});
        end
        wr(8'h40, 8'h2d);
        cyc(5);
        rd(8'h40, 8'h3d);
        note(3'h2, 8'h00);
        wr(8'h40, 8'h2e);
        cyc(5);
        rd(8'h40, 8'h2e);
        note(3'h2, 8'h01);
        wr(8'h40, 8'h8d);
        cyc(5);
        rd(8'h40, 8'h9d);
        note(3'h4, 8'h00);
        wr(8'h00, 8'had);
        rd(8'h00, 8'hbd);
        note(3'h1, 8'h03);
        wr(8'h00, 8'hae);
        cyc(5);
        rd(8'h00, 8'hae);
        note(3'h1, 8'h01);
        wr(8'h00, 8'ha5);
        rd(8'h00, 8'ha5);
        note(3'h1, 8'h01);
        wr(8'h00, 8'h2d);
        cyc(5);
        rd(8'h00, 8'h3d);
        note(3'h1, 8'h00);
        wr(8'h40, 8'h40);
        drv_en = 2'h2;
        cyc(6);
        rd(8'h40, 8'h40);
        note(3'h3, 8'h00);
        drv_en = 2'h0;
        cyc(6);
        note(3'h3, 8'h01);
        wr(8'h40, 8'h00);
        cyc(6);
        note(3'h3, 8'h00);
        drv_en = 2'h2;
        k = 0;
        while (irq !== 1'b1 && k < 10) begin
            @(negedge ref_clk_in);
            k++;
        end
        note(3'h3, 8'h01);
        cyc(1);
        note(3'h3, 8'h00);
        cyc(2);
        tally_and_finish();
    end
endmodule
